// ---- design/flash_cmd_defs.svh ----
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// Opcodes.
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_VWREN 8'h50
`define OP_BLK_LOCK 8'h36
`define OP_BLK_UNLOCK 8'h39
`define OP_BLK_STATUS 8'h3D
`define OP_GLB_LOCK 8'h7E
`define OP_GLB_UNLOCK 8'h98
`define OP_RD_SR1 8'h05
`define OP_RD_SR2 8'h35
`define OP_RD_CR 8'h15
`define OP_WR_SR1 8'h01
`define OP_WR_SR2 8'h31
`define OP_WR_CR 8'h11
`define OP_RD_EAR 8'hC8
`define OP_WR_EAR 8'h56
`define OP_PAGE_PROG 8'h02
`define OP_PAGE_ERASE 8'h81
`define OP_SECT_ERASE 8'h20
`define OP_BLK32_ERASE 8'h52
`define OP_BLK64_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_BUF_CLEAR 8'h9E
`define OP_BUF_LOAD 8'h9A
`define OP_BUF_READ 8'h9B
`define OP_BUF_WRITE 8'h9C
`define OP_BUF_PROG 8'h9D
`define OP_DEEP_PD 8'hB9
`define OP_RELEASE_PD 8'hAB
`define OP_SET_READ_PAR 8'hC0
`define OP_FAST_READ 8'h0B
`define OP_WRAP_READ 8'h0C
`define OP_QUAD_READ 8'hEB
`define OP_MFR_ID 8'h90
`define OP_JEDEC_ID 8'h9F
`define OP_EXIT_QUAD 8'hFF
`define OP_DTR_FAST 8'h0D
`define OP_DTR_TWO 8'hBD
`define OP_DTR_FOUR 8'hED
`define OP_DTR_WRAP 8'h0E

// Frame shape counts.
`define ADDR_BYTES 2'd3
`define JEDEC_BYTES 2'd3

// Reset values of the small registers this block holds.
`define RST_READ_PAR 8'h00
`define RST_EAR 8'h00

`endif

// ---- design/flash_cmd_pkg.sv ----
package flash_cmd_pkg;

    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DUMMY = 3'b010,
        ST_DIN = 3'b011,
        ST_DOUT = 3'b100,
        ST_IGNORE = 3'b101
    } frame_state_e;

    typedef enum logic [1:0] {
        LANES_ONE = 2'b00,
        LANES_TWO = 2'b01,
        LANES_FOUR = 2'b10
    } lanes_e;

    // Shape of a frame as the opcode dictates it.
    typedef struct packed {
        logic known;
        logic has_addr;
        logic has_dummy;
        logic has_din;
        logic has_dout;
        logic double_rate;
        lanes_e lanes;
    } cmd_shape_s;

    typedef logic [7:0] byte_t;

endpackage

// ---- design/link_sampler.sv ----
`timescale 1ns/1ps
`default_nettype none

// Brings the host pins into sys_clk and reports link clock edges.
module link_sampler (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sck_pin,
    input wire logic cs_n_pin,
    input wire logic [3:0] io_pin,
    output logic sck_rise,
    output logic sck_fall,
    output logic cs_n_s,
    output logic [3:0] io_s
);
    logic [1:0] sck_r, sck_nxt;
    logic [1:0] cs_r, cs_nxt;
    logic [3:0] io_a_r, io_a_nxt, io_b_r, io_b_nxt;
    logic sck_d_r, sck_d_nxt;

    // The first stage feeds only the second stage; edges use stage two and its delay.
    always_comb begin
        sck_nxt = {sck_r[0], sck_pin};
        cs_nxt = {cs_r[0], cs_n_pin};
        io_a_nxt = io_pin;
        io_b_nxt = io_a_r;
        sck_d_nxt = sck_r[1];
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sck_r <= 2'b00;
            cs_r <= 2'b11;
            io_a_r <= 4'h0;
            io_b_r <= 4'h0;
            sck_d_r <= 1'b0;
        end else begin
            sck_r <= sck_nxt;
            cs_r <= cs_nxt;
            io_a_r <= io_a_nxt;
            io_b_r <= io_b_nxt;
            sck_d_r <= sck_d_nxt;
        end
    end

    assign sck_rise = sck_r[1] & ~sck_d_r;
    assign sck_fall = ~sck_r[1] & sck_d_r;
    assign cs_n_s = cs_r[1];
    assign io_s = io_b_r;
endmodule

`default_nettype wire

// ---- design/quad_dtr_flash_command_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "flash_cmd_defs.svh"

module quad_dtr_flash_command_decoder
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A,     // Arbitrary identity value.
    parameter logic [15:0] DEVICE_CODE = 16'h1234, // Arbitrary identity value.
    parameter logic [7:0] ELEC_ID = 8'h17         // Arbitrary identity value.
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_mode_enter,
    output logic quad_mode,
    output logic write_enable_latch,
    output logic volatile_write,
    output logic deep_power_down,
    output logic suspended,
    output logic [7:0] status1,
    output logic [7:0] status2,
    output logic [7:0] config_reg,
    output logic [7:0] ext_addr,
    output logic [7:0] read_params,
    input wire logic [7:0] array_data,
    input wire logic blk_lock_state,
    output logic [7:0] cmd_code,
    output logic [23:0] cmd_addr,
    output logic cmd_strobe,
    output logic [7:0] wdata,
    output logic wdata_strobe,
    output logic rdata_req
);
    logic sck_rise, sck_fall, cs_n_s;
    logic [3:0] io_s;

    link_sampler u_sampler (
        .sys_clk(sys_clk),
        .reset(reset),
        .sck_pin(sck),
        .cs_n_pin(cs_n),
        .io_pin(io_in),
        .sck_rise(sck_rise),
        .sck_fall(sck_fall),
        .cs_n_s(cs_n_s),
        .io_s(io_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Opcode table.

    function automatic cmd_shape_s decode(input byte_t op, input logic quad);
        cmd_shape_s s;
        s = '{known: 1'b1, has_addr: 1'b0, has_dummy: 1'b0, has_din: 1'b0,
              has_dout: 1'b0, double_rate: 1'b0,
              lanes: quad ? LANES_FOUR : LANES_ONE};
        case (op)
            `OP_WREN, `OP_WRDI, `OP_VWREN, `OP_GLB_LOCK, `OP_GLB_UNLOCK,
            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_SUSPEND, `OP_RESUME,
            `OP_BUF_CLEAR, `OP_DEEP_PD, `OP_EXIT_QUAD: begin
            end
            `OP_BLK_LOCK, `OP_BLK_UNLOCK, `OP_PAGE_ERASE, `OP_SECT_ERASE,
            `OP_BLK32_ERASE, `OP_BLK64_ERASE, `OP_BUF_LOAD, `OP_BUF_PROG: begin
                s.has_addr = 1'b1;
            end
            `OP_BLK_STATUS, `OP_RELEASE_PD, `OP_MFR_ID: begin
                s.has_addr = 1'b1;
                s.has_dout = 1'b1;
            end
            `OP_RD_SR1, `OP_RD_SR2, `OP_RD_CR, `OP_RD_EAR, `OP_JEDEC_ID: begin
                s.has_dout = 1'b1;
            end
            `OP_WR_SR1, `OP_WR_SR2, `OP_WR_CR, `OP_WR_EAR, `OP_SET_READ_PAR: begin
                s.has_din = 1'b1;
            end
            `OP_PAGE_PROG, `OP_BUF_WRITE: begin
                s.has_addr = 1'b1;
                s.has_din = 1'b1;
            end
            `OP_FAST_READ, `OP_WRAP_READ, `OP_QUAD_READ, `OP_BUF_READ: begin
                s.has_addr = 1'b1;
                s.has_dummy = 1'b1;
                s.has_dout = 1'b1;
                if (op == `OP_QUAD_READ) begin
                    s.lanes = LANES_FOUR;
                end
            end
            `OP_DTR_FAST, `OP_DTR_TWO, `OP_DTR_FOUR, `OP_DTR_WRAP: begin
                s.has_addr = 1'b1;
                s.has_dummy = 1'b1;
                s.has_dout = 1'b1;
                s.double_rate = 1'b1;
                if (op == `OP_DTR_TWO) begin
                    s.lanes = LANES_TWO;
                end else if (op == `OP_DTR_FOUR) begin
                    s.lanes = LANES_FOUR;
                end
                if (op == `OP_DTR_WRAP && !quad) begin
                    s.known = 1'b0;
                end
            end
            default: s.known = 1'b0;
        endcase
        return s;
    endfunction

    // Bits per beat for a lane count.
    function automatic logic [3:0] beat_bits(input lanes_e l);
        return (l == LANES_FOUR) ? 4'd4 : (l == LANES_TWO) ? 4'd2 : 4'd1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer.

    frame_state_e state_r, state_nxt;
    cmd_shape_s shape_r, shape_nxt;
    logic [7:0] op_r, op_nxt, sh_r, sh_nxt, out_r, out_nxt;
    logic [3:0] bits_r, bits_nxt;
    logic [1:0] bytes_r, bytes_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic quad_r, quad_nxt, wel_r, wel_nxt, vwe_r, vwe_nxt, dpd_r, dpd_nxt;
    logic sus_r, sus_nxt, oe_r, oe_nxt, strobe_r, strobe_nxt, wstb_r, wstb_nxt;
    logic rreq_r, rreq_nxt;
    logic [7:0] sr1_r, sr1_nxt, sr2_r, sr2_nxt, cr_r, cr_nxt, ear_r, ear_nxt;
    logic [7:0] rp_r, rp_nxt, wd_r, wd_nxt;
    logic [3:0] io_drv_r, io_drv_nxt;
    logic beat, out_beat;
    logic [3:0] nb;
    logic [7:0] shifted;

    // Double-rate beats.
    // Opcode moves on rises only; later phases also use falling edges.
    assign beat = sck_rise | (shape_r.double_rate && state_r != ST_OPCODE && sck_fall);
    assign out_beat = sck_fall | (shape_r.double_rate && sck_rise);

    // Register reads.
    // Next byte to present, chosen by the opcode.
    function automatic byte_t reply(input byte_t op, input logic [1:0] idx,
                                    input byte_t s1, input byte_t s2, input byte_t c,
                                    input byte_t e, input byte_t arr, input logic lk);
        case (op)
            `OP_RD_SR1: return s1;
            `OP_RD_SR2: return s2;
            `OP_RD_CR: return c;
            `OP_RD_EAR: return e;
            `OP_BLK_STATUS: return {7'h00, lk};
            `OP_RELEASE_PD: return ELEC_ID;
            `OP_JEDEC_ID, `OP_MFR_ID:
                return (idx == 2'd0) ? MAKER_CODE :
                       (idx == 2'd1) ? DEVICE_CODE[15:8] : DEVICE_CODE[7:0];
            default: return arr;
        endcase
    endfunction

    always_comb begin
        state_nxt = state_r;
        shape_nxt = shape_r;
        op_nxt = op_r;
        sh_nxt = sh_r;
        out_nxt = out_r;
        bits_nxt = bits_r;
        bytes_nxt = bytes_r;
        addr_nxt = addr_r;
        quad_nxt = quad_r | quad_mode_enter;
        wel_nxt = wel_r;
        vwe_nxt = vwe_r;
        dpd_nxt = dpd_r;
        sus_nxt = sus_r;
        oe_nxt = oe_r;
        strobe_nxt = 1'b0;
        wstb_nxt = 1'b0;
        rreq_nxt = 1'b0;
        sr1_nxt = sr1_r;
        sr2_nxt = sr2_r;
        cr_nxt = cr_r;
        ear_nxt = ear_r;
        rp_nxt = rp_r;
        wd_nxt = wd_r;
        io_drv_nxt = io_drv_r;
        nb = beat_bits(shape_r.lanes);
        // Beat shift-in.
        // Higher lines carry the more significant bit of each beat.
        unique case (shape_r.lanes)
            LANES_FOUR: shifted = {sh_r[3:0], io_s};
            LANES_TWO: shifted = {sh_r[5:0], io_s[1:0]};
            default: shifted = {sh_r[6:0], io_s[0]};
        endcase
        if (cs_n_s) begin
            // Deselect ends every frame and rearms opcode capture.
            state_nxt = ST_OPCODE;
            shape_nxt = decode(8'h00, quad_r);
            shape_nxt.lanes = quad_r ? LANES_FOUR : LANES_ONE;
            shape_nxt.double_rate = 1'b0;
            bits_nxt = 4'd0;
            bytes_nxt = 2'd0;
            oe_nxt = 1'b0;
        end else if (state_r == ST_DOUT && out_beat) begin
            // Output lanes.
            // The byte goes out most significant group first.
            unique case (shape_r.lanes)
                LANES_FOUR: io_drv_nxt = out_r[7:4];
                LANES_TWO: io_drv_nxt = {2'b00, out_r[7:6]};
                default: io_drv_nxt = {2'b00, out_r[7], 1'b0};
            endcase
            oe_nxt = 1'b1;
            out_nxt = (shape_r.lanes == LANES_FOUR) ? {out_r[3:0], 4'h0} :
                      (shape_r.lanes == LANES_TWO) ? {out_r[5:0], 2'b00} :
                      {out_r[6:0], 1'b0};
            if (bits_r + nb >= 4'd8) begin
                // Continuous stream.
                // Readout never ends on its own; deselect stops it.
                bits_nxt = 4'd0;
                bytes_nxt = (bytes_r == `JEDEC_BYTES - 2'd1) ? bytes_r : bytes_r + 2'd1;
                out_nxt = reply(op_r, bytes_nxt, sr1_r, sr2_r, cr_r, ear_r,
                                array_data, blk_lock_state);
                rreq_nxt = 1'b1;
            end else begin
                bits_nxt = bits_r + nb;
            end
        end else if (beat && state_r != ST_DOUT && state_r != ST_IGNORE) begin
            sh_nxt = shifted;
            bits_nxt = bits_r + nb;
            if (bits_r + nb >= 4'd8) begin
                bits_nxt = 4'd0;
                unique case (state_r)
                    ST_OPCODE: begin
                        op_nxt = shifted;
                        shape_nxt = decode(shifted, quad_r);
                        bytes_nxt = 2'd0;
                        if (!shape_nxt.known || (dpd_r && shifted != `OP_RELEASE_PD)) begin
                            state_nxt = ST_IGNORE;
                        end else if (shape_nxt.has_addr) begin
                            state_nxt = ST_ADDR;
                        end else if (shape_nxt.has_din) begin
                            state_nxt = ST_DIN;
                        end else if (shape_nxt.has_dout) begin
                            state_nxt = ST_DOUT;
                            out_nxt = reply(shifted, 2'd0, sr1_r, sr2_r, cr_r, ear_r,
                                            array_data, blk_lock_state);
                        end else begin
                            state_nxt = ST_IGNORE;
                            strobe_nxt = 1'b1;
                        end
                        // A refused opcode, power-down included, must leave every flag alone.
                        if (shape_nxt.known && !(dpd_r && shifted != `OP_RELEASE_PD)) begin
                            if (shifted == `OP_WREN) wel_nxt = 1'b1;
                            if (shifted == `OP_WRDI) wel_nxt = 1'b0;
                            if (shifted == `OP_VWREN) vwe_nxt = 1'b1;
                            if (shifted == `OP_SUSPEND) sus_nxt = 1'b1;
                            if (shifted == `OP_RESUME) sus_nxt = 1'b0;
                            if (shifted == `OP_DEEP_PD) dpd_nxt = 1'b1;
                            if (shifted == `OP_RELEASE_PD) dpd_nxt = 1'b0;
                            if (shifted == `OP_EXIT_QUAD) quad_nxt = 1'b0;
                        end
                        // Commands with no address and no data phase reach the core by strobe.
                    end
                    ST_ADDR: begin
                        addr_nxt = {addr_r[15:0], shifted};
                        bytes_nxt = bytes_r + 2'd1;
                        if (bytes_r == `ADDR_BYTES - 2'd1) begin
                            bytes_nxt = 2'd0;
                            strobe_nxt = 1'b1;
                            if (shape_r.has_dummy) begin
                                state_nxt = ST_DUMMY;
                            end else if (shape_r.has_din) begin
                                state_nxt = ST_DIN;
                            end else if (shape_r.has_dout) begin
                                state_nxt = ST_DOUT;
                                out_nxt = reply(op_r, 2'd0, sr1_r, sr2_r, cr_r, ear_r,
                                                array_data, blk_lock_state);
                            end else begin
                                state_nxt = ST_IGNORE;
                            end
                        end
                    end
                    ST_DUMMY: begin
                        state_nxt = ST_DOUT;
                        out_nxt = array_data;
                        rreq_nxt = 1'b1;
                    end
                    ST_DIN: begin
                        wd_nxt = shifted;
                        wstb_nxt = 1'b1;
                        if (op_r == `OP_WR_SR1) sr1_nxt = shifted;
                        if (op_r == `OP_WR_SR2) sr2_nxt = shifted;
                        if (op_r == `OP_WR_CR) cr_nxt = shifted;
                        if (op_r == `OP_WR_EAR) ear_nxt = shifted;
                        if (op_r == `OP_SET_READ_PAR) rp_nxt = shifted;
                        if (op_r == `OP_WR_SR1 || op_r == `OP_WR_SR2 || op_r == `OP_WR_CR) begin
                            vwe_nxt = 1'b0;
                        end
                        if (op_r != `OP_PAGE_PROG && op_r != `OP_BUF_WRITE) begin
                            state_nxt = ST_IGNORE;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Everything registers here; the host relies on no state beyond reset.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= ST_OPCODE;
            shape_r <= '0;
            op_r <= 8'h00;
            sh_r <= 8'h00;
            out_r <= 8'h00;
            bits_r <= 4'd0;
            bytes_r <= 2'd0;
            addr_r <= 24'h00_0000;
            quad_r <= 1'b0;
            wel_r <= 1'b0;
            vwe_r <= 1'b0;
            dpd_r <= 1'b0;
            sus_r <= 1'b0;
            oe_r <= 1'b0;
            strobe_r <= 1'b0;
            wstb_r <= 1'b0;
            rreq_r <= 1'b0;
            sr1_r <= 8'h00;
            sr2_r <= 8'h00;
            cr_r <= 8'h00;
            ear_r <= `RST_EAR;
            rp_r <= `RST_READ_PAR;
            wd_r <= 8'h00;
            io_drv_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            shape_r <= shape_nxt;
            op_r <= op_nxt;
            sh_r <= sh_nxt;
            out_r <= out_nxt;
            bits_r <= bits_nxt;
            bytes_r <= bytes_nxt;
            addr_r <= addr_nxt;
            quad_r <= quad_nxt;
            wel_r <= wel_nxt;
            vwe_r <= vwe_nxt;
            dpd_r <= dpd_nxt;
            sus_r <= sus_nxt;
            oe_r <= oe_nxt;
            strobe_r <= strobe_nxt;
            wstb_r <= wstb_nxt;
            rreq_r <= rreq_nxt;
            sr1_r <= sr1_nxt;
            sr2_r <= sr2_nxt;
            cr_r <= cr_nxt;
            ear_r <= ear_nxt;
            rp_r <= rp_nxt;
            wd_r <= wd_nxt;
            io_drv_r <= io_drv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; single-line output uses line 1 as the serial data out.

    assign io_out = io_drv_r;
    assign io_oe = !oe_r ? 4'h0 : (shape_r.lanes == LANES_FOUR) ? 4'hF :
                   (shape_r.lanes == LANES_TWO) ? 4'h3 : 4'h2;
    assign quad_mode = quad_r;
    assign write_enable_latch = wel_r;
    assign volatile_write = vwe_r;
    assign deep_power_down = dpd_r;
    assign suspended = sus_r;
    assign status1 = sr1_r;
    assign status2 = sr2_r;
    assign config_reg = cr_r;
    assign ext_addr = ear_r;
    assign read_params = rp_r;
    assign cmd_code = op_r;
    assign cmd_addr = addr_r;
    assign cmd_strobe = strobe_r;
    assign wdata = wd_r;
    assign wdata_strobe = wstb_r;
    assign rdata_req = rreq_r;
endmodule

`default_nettype wire

// ---- tb/decoder_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.svh"

// Each mode change checked here must trace back to the opcode that causes it.
module decoder_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic [3:0] io_oe,
    input wire logic write_enable_latch,
    input wire logic deep_power_down,
    input wire logic suspended,
    input wire logic quad_mode,
    input wire logic [7:0] config_reg,
    input wire logic [7:0] cmd_code
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // The opcode register may land up to two cycles apart from its effect.
    sequence op_seen(logic [7:0] c);
        ##[0:2] cmd_code == c;
    endsequence
    // Eight cycles covers the chip-select synchroniser, so no beat is in flight.
    sequence deselected;
        cs_n [*8];
    endsequence
    AST_WEL_SET: assert property ($rose(write_enable_latch) |-> op_seen(`OP_WREN))
        else $error("latch set by wrong opcode");
    AST_PD_ON: assert property ($rose(deep_power_down) |-> op_seen(`OP_DEEP_PD))
        else $error("power-down entered by wrong opcode");
    AST_PD_OFF: assert property ($fell(deep_power_down) |-> op_seen(`OP_RELEASE_PD))
        else $error("power-down left by wrong opcode");
    AST_SUSP_ON: assert property ($rose(suspended) |-> op_seen(`OP_SUSPEND))
        else $error("suspend by wrong opcode");
    AST_SUSP_OFF: assert property ($fell(suspended) |-> op_seen(`OP_RESUME))
        else $error("resume by wrong opcode");
    AST_CFG_WRITE: assert property ($changed(config_reg) |-> op_seen(`OP_WR_CR))
        else $error("configuration changed by wrong opcode");
    AST_QUAD_EXIT: assert property ($fell(quad_mode) |-> op_seen(`OP_EXIT_QUAD))
        else $error("four-line mode left by wrong opcode");
    AST_OE_IDLE: assert property (deselected |-> io_oe == 4'h0)
        else $error("lines driven while deselected");
endmodule

bind quad_dtr_flash_command_decoder decoder_checker chk_u (
    .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .io_oe(io_oe),
    .write_enable_latch(write_enable_latch), .deep_power_down(deep_power_down),
    .suspended(suspended), .quad_mode(quad_mode), .config_reg(config_reg),
    .cmd_code(cmd_code)
);
`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host controller: mode-0 link clock that stands still between frames.
module host_model
    import flash_cmd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [3:0] io_in,
    output logic sck,
    output logic cs_n,
    output logic [3:0] hdrv
);
    int ph = 0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        hdrv = 4'h0;
    end
    // Alternating 12 and 13 cycles gives a 125 ns link period.
    task automatic half();
        repeat (12 + ph) @(posedge sys_clk);
        ph = 1 - ph;
    endtask
    // Data changes while the clock is low; both sides sample on the rise.
    task automatic beat(input logic [3:0] v, output logic [3:0] s);
        hdrv <= v;
        half();
        sck <= 1'b1;
        s = io_in;
        half();
        sck <= 1'b0;
    endtask
    task automatic frame(input logic q, input byte_t op, input int na, input int nd,
                         input byte_t d, input int nr, output logic [31:0] rd);
        logic [63:0] sh;
        logic [3:0] s;
        sh = (na != 0) ? {op, 24'h12_3456, d, 24'h00_0000} : {op, d, 48'h0};
        rd = '0;
        cs_n <= 1'b0;
        for (int i = 0; i < 8 * (1 + na + nd); i += (q ? 4 : 1)) begin
            beat(q ? sh[63:60] : {3'b000, sh[63]}, s);
            sh = q ? sh << 4 : sh << 1;
        end
        // A released line toggles every beat, so a stale value never looks right.
        for (int i = 0; i < 8 * nr; i += (q ? 4 : 1)) begin
            beat(~hdrv, s);
            rd = q ? {rd[27:0], s} : {rd[30:0], s[1]};
        end
        half();
        cs_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench
    import flash_cmd_pkg::*;
;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary identity value.
    localparam logic [15:0] DEVICE = 16'h1234; // Arbitrary identity value.
    typedef struct {byte_t op; int na; int nd; byte_t d; int sel; byte_t exp;} row_s;
    logic sys_clk, reset, sck, cs_n, qe, quad_mode, wel, pd, susp, vw;
    logic [3:0] io_in, io_out, io_oe, hdrv;
    logic [7:0] cfg, ear, rpar, code, sr1, sr2;
    logic [23:0] addr;
    logic [31:0] rd;
    logic [7:0] obs [11];
    int err_count = 0;
    int checks_done = 0;
    // Each row: opcode, address and data counts, data, observed output, expected value.
    row_s rows [17] = '{
        '{8'h06, 0, 0, 8'h00, 0, 8'h01},
        '{8'h11, 0, 1, 8'hA5, 3, 8'hA5},
        '{8'h04, 0, 0, 8'h00, 0, 8'h00},
        '{8'h56, 0, 1, 8'h3C, 4, 8'h3C},
        '{8'hC0, 0, 1, 8'h21, 5, 8'h21},
        '{8'hC0, 0, 1, 8'h00, 5, 8'h00},
        '{8'h75, 0, 0, 8'h00, 2, 8'h01},
        '{8'h7A, 0, 0, 8'h00, 2, 8'h00},
        '{8'hD8, 3, 0, 8'h00, 6, 8'h56},
        '{8'h7E, 0, 0, 8'h00, 7, 8'h7E},
        '{8'h50, 0, 0, 8'h00, 8, 8'h01},
        '{8'h01, 0, 1, 8'h81, 9, 8'h81},
        '{8'h31, 0, 1, 8'h42, 10, 8'h42},
        '{8'h9D, 3, 0, 8'h00, 8, 8'h00},
        '{8'hB9, 0, 0, 8'h00, 1, 8'h01},
        '{8'h06, 0, 0, 8'h00, 0, 8'h00},
        '{8'hAB, 3, 0, 8'h00, 1, 8'h00}
    };
    assign obs = '{{7'h0, wel}, {7'h0, pd}, {7'h0, susp}, cfg, ear, rpar, addr[7:0], code,
                   {7'h0, vw}, sr1, sr2};
    // Each line carries whichever party enables it.
    assign io_in = (io_oe & io_out) | (~io_oe & hdrv);

    quad_dtr_flash_command_decoder #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) dut_u (
        .sys_clk(sys_clk), .reset(reset), .sck(sck), .cs_n(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .quad_mode_enter(qe), .quad_mode(quad_mode),
        .write_enable_latch(wel), .volatile_write(vw), .deep_power_down(pd),
        .suspended(susp), .status1(sr1), .status2(sr2), .config_reg(cfg), .ext_addr(ear),
        .read_params(rpar), .array_data(8'hC3), .blk_lock_state(1'b0), .cmd_code(code),
        .cmd_addr(addr), .cmd_strobe(), .wdata(), .wdata_strobe(), .rdata_req());
    host_model host_u (.sys_clk(sys_clk), .io_in(io_in), .sck(sck), .cs_n(cs_n), .hdrv(hdrv));

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A whole run needs about 9700 cycles; the margin keeps slow frames legal.
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        test_done();
    end
    // Table first, then reads, a bad opcode and the four-line frames.
    initial begin
        reset = 1'b1;
        qe = 1'b0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        foreach (rows[i]) begin
            host_u.frame(1'b0, rows[i].op, rows[i].na, rows[i].nd, rows[i].d, 0, rd);
            chk(obs[rows[i].sel], rows[i].exp);
            $display("row %0d done", i);
        end
        host_u.frame(1'b0, 8'h15, 0, 0, 8'h00, 1, rd);
        chk(rd, 32'h0000_00A5);
        host_u.frame(1'b0, 8'h9F, 0, 0, 8'h00, 3, rd);
        chk(rd, {8'h00, MAKER, DEVICE});
        host_u.frame(1'b0, 8'h00, 0, 0, 8'h00, 2, rd);
        // A released line shows the host's own toggling, never a stale device bit.
        chk(rd[1], !rd[0]);
        host_u.frame(1'b0, 8'h06, 0, 0, 8'h00, 0, rd);
        chk(wel, 1'b1);
        $display("serial frames done");
        qe <= 1'b1;
        @(posedge sys_clk);
        qe <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk(quad_mode, 1'b1);
        host_u.frame(1'b1, 8'h04, 0, 0, 8'h00, 0, rd);
        chk(wel, 1'b0);
        host_u.frame(1'b1, 8'hC8, 0, 0, 8'h00, 1, rd);
        chk(rd, 32'h0000_003C);
        host_u.frame(1'b1, 8'h0B, 3, 1, 8'h00, 2, rd);
        chk(rd, 32'h0000_C3C3);
        host_u.frame(1'b1, 8'hFF, 0, 0, 8'h00, 0, rd);
        chk(quad_mode, 1'b0);
        $display("four-line frames done");
        // Single-line opcodes work again, then a mid-run reset clears the flags.
        host_u.frame(1'b0, 8'h06, 0, 0, 8'h00, 0, rd);
        chk(wel, 1'b1);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk({wel, cfg, quad_mode}, 10'h000);
        $display("reset test done");
        test_done();
    end
endmodule
`default_nettype wire
